// [shared/serial_tx_pkg.sv]
`default_nettype none
package serial_tx_pkg;

  // Register byte offsets on the Wishbone slave; one aligned word per register.
  localparam logic [7:0] transmit_status_control_off = 8'h00;
  localparam logic [7:0] receive_status_control_off  = 8'h04;
  localparam logic [7:0] baud_control_off            = 8'h08;
  localparam logic [7:0] baud_divisor_off            = 8'h0C;
  localparam logic [7:0] transmit_buffer_off         = 8'h10;
  localparam logic [7:0] peripheral_flag_reg_off     = 8'h14;
  localparam logic [7:0] peripheral_enable_reg_off   = 8'h18;

  // Field positions in transmit_status_control.
  localparam int ninth_data_bit_pos       = 0;
  localparam int shift_register_empty_pos = 1;
  localparam int sync_select_pos          = 4;
  localparam int transmit_enable_pos      = 5;
  localparam int nine_bit_select_pos      = 6;
  // Field positions elsewhere.
  localparam int serial_port_enable_pos   = 7;
  localparam int polarity_select_pos      = 4;
  localparam int divisor_16_pos           = 3;
  localparam int transmit_buffer_empty_pos = 4;
  localparam int transmit_interrupt_enable_pos = 4;

  // Values after reset.
  localparam logic [15:0] baud_divisor_reset = 16'h0000;
  localparam logic [7:0]  control_reset      = 8'h00;

  // Stop bit count and the delay before the empty flag tracks a write.
  localparam logic [3:0] stop_bits         = 4'h1;
  localparam logic [1:0] flag_settle_cycles = 2'h2;

  // Transmitter states.
  typedef enum logic [2:0]
  {
    st_idle  = 3'b001,
    st_start = 3'b010,
    st_data  = 3'b100
  } tx_state_t;

endpackage
`default_nettype wire

// [src/baud_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// Divides the system clock down to one tick per baud period.
module baud_tick_gen
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        run_i,
  input  wire logic        wide_i,
  input  wire logic [15:0] divisor_i,
  output logic             tick_o
);
  import serial_tx_pkg::*;

  typedef struct packed
  {
    logic [15:0] count;
  } gen_state_t;

  gen_state_t cur;
  gen_state_t next_cur;
  logic [15:0] limit;

  // Eight-bit mode ignores the high divisor byte, so a period is limit+1 clocks.
  always_comb
  begin
    limit    = wide_i ? divisor_i : {8'h00, divisor_i[7:0]};
    next_cur = cur;
    if (!run_i)
    begin
      next_cur.count = 16'h0000;
    end
    else if (cur.count >= limit)
    begin
      next_cur.count = 16'h0000;
    end
    else
    begin
      next_cur.count = cur.count + 16'h0001;
    end
  end

  // Synchronous reset keeps the divider quiet until configured.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // The tick is decoded from the count, not registered, so the first bit after a load
  // lasts the same limit+1 clocks as every later bit.
  assign tick_o = run_i & (cur.count >= limit);

endmodule // baud_tick_gen
`default_nettype wire

// [src/async_serial_transmitter.sv]
// Contract
// - Idle mark, start space, data, stop mark.
// - Every bit lasts one baud period.
// - Data bits leave least significant first.
// - No hardware parity; ninth bit carries it.
// - Baud timing from 8/16-bit divider.
// - Runs only when enabled, async, port on.
// - Buffer write starts; empty shifter loads immediately.
// - Queued character loads right after stop.
// - Frame starts immediately after load.
// - Polarity bit inverts idle and data levels.
// - Buffer-empty flag set only while running with no character queued.
// - Buffer-empty flag valid second cycle after write.
// - Buffer-empty flag read-only, ignores its enable.
// - Shifter-empty set idle, clear while shifting.
// - Shifter-empty raises no interrupt; shifter hidden.
// - Nine-bit mode sends ninth bit last.
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module async_serial_transmitter
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  output logic             tx_o,
  output logic             tx_oe_o,
  output logic             tx_irq_o
);
  import serial_tx_pkg::*;

  typedef struct packed
  {
    logic [7:0]  tsc;          // transmit_status_control writable bits
    logic [7:0]  rsc;          // receive_status_control
    logic [7:0]  bcon;         // baud_control
    logic [15:0] divisor;      // baud_divisor
    logic        irq_en;       // transmit_interrupt_enable
    logic [8:0]  buffer;       // transmit_buffer with ninth bit
    logic        buf_full;
    logic [8:0]  shifter;      // transmit_shift_register
    logic [3:0]  bit_cnt;
    tx_state_t   state;
    logic        tbe_flag;     // transmit_buffer_empty_flag as seen by software
    logic [1:0]  settle;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
    logic        line;
    logic        oe;
    logic        irq;
  } tx_reg_t;

  tx_reg_t cur;
  tx_reg_t next_cur;
  logic    tick;
  logic    run;
  logic    bus_req;
  logic    wr_buf;
  logic    sr_empty;
  logic    raw_empty;
  logic [3:0] char_bits;

  // Byte-lane write merge used by the control, baud and divisor registers.
  function automatic logic [7:0] merge_lane(input logic [7:0] old, input logic en,
                                            input logic [7:0] val);
    merge_lane = en ? val : old;
  endfunction

  // All three enables must agree before the transmitter may run.
  assign run = cur.tsc[transmit_enable_pos] & ~cur.tsc[sync_select_pos]
             & cur.rsc[serial_port_enable_pos];

  baud_tick_gen u_baud
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .run_i     (run && cur.state != st_idle),
    .wide_i    (cur.bcon[divisor_16_pos]),
    .divisor_i (cur.divisor),
    .tick_o    (tick)
  );

  assign bus_req   = cyc_i & stb_i & ~cur.ack & ~cur.err;
  assign wr_buf    = bus_req & we_i & sel_i[0] & (adr_i == transmit_buffer_off);
  assign sr_empty  = (cur.state == st_idle);
  assign raw_empty = ~cur.buf_full;
  assign char_bits = cur.tsc[nine_bit_select_pos] ? 4'd9 : 4'd8;

  // One combinational pass computes the whole next state.
  always_comb
  begin
    next_cur     = cur;
    next_cur.ack = 1'b0;
    next_cur.err = 1'b0;

    // Wishbone decode; an unmapped offset is answered with err, a write to a read-only place is ignored.
    if (bus_req)
    begin
      next_cur.rdata = 32'h0000_0000;
      if (adr_i == transmit_status_control_off)
      begin
        if (we_i)
        begin
          // Shifter-empty is status; all eight bits are stored, but the read shows sr_empty in its place.
          next_cur.tsc = merge_lane(cur.tsc, sel_i[0], dat_i[7:0]);
        end
        next_cur.rdata[7:0] = cur.tsc;
        next_cur.rdata[shift_register_empty_pos] = sr_empty;
        next_cur.ack = 1'b1;
      end
      else if (adr_i == receive_status_control_off)
      begin
        if (we_i)
        begin
          next_cur.rsc = merge_lane(cur.rsc, sel_i[0], dat_i[7:0]);
        end
        next_cur.rdata[7:0] = cur.rsc;
        next_cur.ack = 1'b1;
      end
      else if (adr_i == baud_control_off)
      begin
        if (we_i)
        begin
          next_cur.bcon = merge_lane(cur.bcon, sel_i[0], dat_i[7:0]);
        end
        next_cur.rdata[7:0] = cur.bcon;
        next_cur.ack = 1'b1;
      end
      else if (adr_i == baud_divisor_off)
      begin
        if (we_i)
        begin
          next_cur.divisor[7:0]  = merge_lane(cur.divisor[7:0], sel_i[0], dat_i[7:0]);
          next_cur.divisor[15:8] = merge_lane(cur.divisor[15:8], sel_i[1], dat_i[15:8]);
        end
        next_cur.rdata[15:0] = cur.divisor;
        next_cur.ack = 1'b1;
      end
      else if (adr_i == transmit_buffer_off)
      begin
        // The buffer reads as zero; a write queues a character.
        next_cur.ack = 1'b1;
      end
      else if (adr_i == peripheral_flag_reg_off)
      begin
        // Flag is read-only; writes have no effect on it.
        next_cur.rdata[transmit_buffer_empty_pos] = cur.tbe_flag;
        next_cur.ack = 1'b1;
      end
      else if (adr_i == peripheral_enable_reg_off)
      begin
        if (we_i && sel_i[0])
        begin
          next_cur.irq_en = dat_i[transmit_interrupt_enable_pos];
        end
        next_cur.rdata[transmit_interrupt_enable_pos] = cur.irq_en;
        next_cur.ack = 1'b1;
      end
      else
      begin
        next_cur.err = 1'b1;
      end
    end

    // Accept a character; the ninth bit is taken from the control register now.
    if (wr_buf)
    begin
      next_cur.buffer   = {cur.tsc[ninth_data_bit_pos], dat_i[7:0]};
      next_cur.buf_full = 1'b1;
      next_cur.settle   = flag_settle_cycles;
    end

    // Transmit sequencer.
    case (cur.state)
      st_idle:
      begin
        next_cur.line = 1'b1;
        if (run && cur.buf_full)
        begin
          // Load at once when the shifter is empty.
          next_cur.shifter  = cur.buffer;
          next_cur.buf_full = wr_buf;
          next_cur.state    = st_start;
          next_cur.line     = 1'b0;
        end
      end
      st_start:
      begin
        if (tick)
        begin
          next_cur.line    = cur.shifter[0];
          next_cur.shifter = {1'b1, cur.shifter[8:1]};
          next_cur.bit_cnt = 4'd1;
          next_cur.state   = st_data;
        end
      end
      st_data:
      begin
        // Each bit stands exactly one tick interval.
        if (tick)
        begin
          if (cur.bit_cnt < char_bits)
          begin
            next_cur.line    = cur.shifter[0];
            next_cur.shifter = {1'b1, cur.shifter[8:1]};
            next_cur.bit_cnt = cur.bit_cnt + 4'd1;
          end
          else if (cur.bit_cnt == char_bits)
          begin
            next_cur.line    = 1'b1;
            next_cur.bit_cnt = cur.bit_cnt + stop_bits;
          end
          else if (cur.buf_full && run)
          begin
            // Back-to-back: next start bit follows the single stop bit.
            next_cur.shifter  = cur.buffer;
            next_cur.buf_full = wr_buf;
            next_cur.line     = 1'b0;
            next_cur.state    = st_start;
          end
          else
          begin
            next_cur.line  = 1'b1;
            next_cur.state = st_idle;
          end
        end
      end
      default:
      begin
        next_cur.state = st_idle;
      end
    endcase

    // Disabling the transmitter aborts the frame and flushes the queue.
    if (!run)
    begin
      next_cur.state    = st_idle;
      next_cur.line     = 1'b1;
      next_cur.buf_full = 1'b0;
    end

    // The software-visible flag lags a write by two cycles.
    if (cur.settle != 2'h0)
    begin
      next_cur.settle = cur.settle - 2'h1;
    end
    if (cur.settle == 2'h0 || cur.settle == 2'h1)
    begin
      next_cur.tbe_flag = run & ~next_cur.buf_full;
    end

    // The enable gates only the request, never the flag.
    next_cur.irq = cur.irq_en & next_cur.tbe_flag;
    next_cur.oe  = cur.rsc[serial_port_enable_pos];
  end

  // Synchronous reset puts every control field to its documented default.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cur          <= '0;
      cur.tsc      <= control_reset;
      cur.rsc      <= control_reset;
      cur.bcon     <= control_reset;
      cur.divisor  <= baud_divisor_reset;
      cur.state    <= st_idle;
      cur.line     <= 1'b1;
      cur.shifter  <= 9'h1FF;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Inversion is applied at the registered pin only in asynchronous mode.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_o <= 1'b1;
    end
    else
    begin
      tx_o <= next_cur.line ^ (next_cur.bcon[polarity_select_pos]
              & ~next_cur.tsc[sync_select_pos]);
    end
  end

  assign dat_o    = cur.rdata;
  assign ack_o    = cur.ack;
  assign err_o    = cur.err;
  assign tx_oe_o  = cur.oe;
  assign tx_irq_o = cur.irq;

endmodule // async_serial_transmitter
`default_nettype wire

// [bench/serial_tx_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_tx_sva
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        tx_o,
  input wire logic        tx_oe_o,
  input wire logic        tx_irq_o
);
  import serial_tx_pkg::*;
  logic spe;
  logic ie;
  logic mapped;
  logic wr;
  // Offsets are word aligned and end at the interrupt enable register.
  assign mapped = adr_i[1:0] == 2'h0 && adr_i <= peripheral_enable_reg_off;
  assign wr = cyc_i && stb_i && we_i && !ack_o && !err_o;
  // Shadow the enables on the edge that takes the write, so outputs can be tied to them.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      spe <= 1'b0;
      ie <= 1'b0;
    end
    else if (wr && adr_i == receive_status_control_off)
      spe <= dat_i[serial_port_enable_pos];
    else if (wr && adr_i == peripheral_enable_reg_off)
      ie <= dat_i[transmit_interrupt_enable_pos];
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  property p_ack_map;
    s_take ##0 mapped |=> ack_o && !err_o;
  endproperty
  a_ack_map: assert property (p_ack_map) else $error("mapped access not acknowledged");
  property p_err_map;
    s_take ##0 !mapped |=> err_o && !ack_o;
  endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_err_pulse;
    err_o |=> !err_o;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err longer than one cycle");
  property p_hide;
    s_take ##0 (!we_i && adr_i == transmit_buffer_off) |=> dat_o == 32'h0000_0000;
  endproperty
  a_hide: assert property (p_hide) else $error("transmit data readable");
  property p_oe;
    tx_oe_o == $past(spe);
  endproperty
  a_oe: assert property (p_oe) else $error("driver enable not following port enable");
  property p_irq;
    tx_irq_o |-> $past(ie);
  endproperty
  a_irq: assert property (p_irq) else $error("request while interrupt disabled");
  property p_rst;
    $fell(rst_i) |-> tx_o && !tx_oe_o && !tx_irq_o;
  endproperty
  a_rst: assert property (p_rst) else $error("line not idle after reset");
endmodule // serial_tx_sva
bind async_serial_transmitter serial_tx_sva sva (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .tx_o, .tx_oe_o, .tx_irq_o);
`default_nettype wire

// [bench/serial_rx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model
(
  input  wire logic       clk_i,
  input  wire logic       line_i,
  input  wire logic       inv_i,
  input  wire logic       arm_i,
  input  wire logic       nine_i,
  input  var  int         bit_cyc_i,
  output var  logic [8:0] data_o,
  output var  logic       stop_ok_o,
  output var  logic       got_o
);
  logic [8:0] d;
  int i;
  // Samples each bit at its middle; disarmed while the bench flips polarity.
  initial
  begin
    got_o <= 1'b0;
    data_o <= 9'h000;
    stop_ok_o <= 1'b0;
    forever
    begin
      @(posedge clk_i);
      got_o <= 1'b0;
      if (arm_i && (line_i ^ inv_i) == 1'b0)
      begin
        d = 9'h000;
        repeat (bit_cyc_i / 2) @(posedge clk_i);
        for (i = 0; i < (nine_i ? 9 : 8); i++)
        begin
          repeat (bit_cyc_i) @(posedge clk_i);
          d[i] = line_i ^ inv_i;
        end
        repeat (bit_cyc_i) @(posedge clk_i);
        stop_ok_o <= line_i ^ inv_i;
        data_o <= d;
        got_o <= 1'b1;
      end
    end
  end
endmodule // serial_rx_model
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import serial_tx_pkg::*;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, tx_o, tx_oe_o, tx_irq_o;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rv, rnd;
  logic pol, nine, arm, got, sok;
  logic [8:0] rxd;
  logic [8:0] q[$];
  int num_errors, n_compared, bitc, fl, cyc, tl, m;

  async_serial_transmitter uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .tx_o, .tx_oe_o, .tx_irq_o);
  serial_rx_model rx (.clk_i, .line_i(tx_o), .inv_i(pol), .arm_i(arm), .nine_i(nine),
    .bit_cyc_i(bitc), .data_o(rxd), .stop_ok_o(sok), .got_o(got));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic test_done;
    $display("Errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic c, input string s);
    n_compared++;
    if (c !== 1'b1)
    begin
      num_errors++;
      $display("MISMATCH %0t %s", $time, s);
    end
  endtask

  task automatic fail(input string s);
    num_errors++;
    $display("MISMATCH %0t %s", $time, s);
    test_done;
  endtask

  // One classic cycle; read data is compared under a mask, a zero mask skips it.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, mk, x,
                     input logic xe);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= (a == baud_divisor_off) ? 4'h3 : 4'h1;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(ack_o || err_o) && n < 20);
    if (n >= 20) fail("no answer");
    chk(err_o === xe, "error answer");
    if (mk != 0) chk((dat_o & mk) === x, "read data");
    rv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Each decoded character meets the oldest expected one; the second of a pair must follow
  // its predecessor start to start by exactly one frame.
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (got)
    begin
      chk(q.size() > 0 && rxd === q[0] && sok === 1'b1, "character");
      if (q.size() == 1) chk(cyc - tl == fl, "frame spacing");
      tl = cyc;
      if (q.size() > 0) void'(q.pop_front());
    end
  end

  initial
  begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 47'h0};
    {pol, nine, arm, bitc, fl, tl, cyc, num_errors, n_compared} = 0;
    rnd = 32'h0000_8eab;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int a = 0; a < 32; a += 4)
      acc(0, a[7:0], 0, 32'h0000_00FF, (a == 0) ? 32'h0000_0002 : 0, a == 28);
    acc(1, baud_divisor_off, 32'h0000_0107, 0, 0, 0);
    acc(1, receive_status_control_off, 32'h0000_0080, 0, 0, 0);
    acc(1, transmit_status_control_off, 32'h0000_0020, 0, 0, 0);
    acc(0, peripheral_flag_reg_off, 0, 32'h0000_0010, 32'h0000_0010, 0);
    acc(1, peripheral_flag_reg_off, 0, 0, 0, 0);
    acc(1, peripheral_enable_reg_off, 32'h0000_0010, 0, 0, 0);
    acc(0, peripheral_flag_reg_off, 0, 32'h0000_0010, 32'h0000_0010, 0);
    chk(tx_irq_o === 1'b1 && tx_oe_o === 1'b1, "request and driver");
    // Modes: eight or nine bits, both polarities, and the wide divisor once.
    for (m = 0; m < 4; m++)
    begin
      nine = m[0];
      arm = 1'b0;
      acc(1, baud_control_off, 32'({m[1], m == 3, 3'h0}), 0, 0, 0);
      pol = m[1];
      bitc = (m == 3) ? 264 : 8;
      fl = bitc * (nine ? 11 : 10);
      arm = 1'b1;
      for (int k = 0; k < 2; k++)
      begin
        rnd = lfsr(rnd);
        acc(1, 0, 32'({1'b0, nine, 1'b1, 4'h0, rnd[8]}), 0, 0, 0);
        acc(1, transmit_buffer_off, 32'(rnd[7:0]), 0, 0, 0);
        q.push_back({nine & rnd[8], rnd[7:0]});
      end
      acc(0, peripheral_flag_reg_off, 0, 32'h0000_0010, 0, 0);
      acc(0, transmit_status_control_off, 0, 32'h0000_0002, 0, 0);
      chk(tx_irq_o === 1'b0, "request while queued");
      for (int n = 0; n < 8000 && q.size() > 0; n++) @(posedge clk_i);
      if (q.size() != 0) fail("characters missing");
      rv = 0;
      for (int n = 0; n < 400 && rv[1] !== 1'b1; n++) acc(0, 0, 0, 0, 0, 0);
      if (rv[1] !== 1'b1) fail("shifter never empty");
      chk(tx_o === !m[1], "idle level");
    end
    acc(1, receive_status_control_off, 0, 0, 0, 0);
    chk(tx_oe_o === 1'b0, "driver released");
    test_done;
  end
endmodule // testbench
`default_nettype wire
